// *** mem_power_sequencer.sv ***
// Power sequencing and power-fail protection for a core-memory cabinet.
// Assumes async pins, same-clock memory requests and an AXI4-Lite master.
`include "mem_power_map.svh"
`timescale 1ns/10ps
module mem_power_sequencer #(
  parameter int MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire mem_power_pkg::pins_t   pins,
  input  wire logic [1:0]             memReq,
  input  wire logic [1:0]             memWrite,
  input  wire mem_power_pkg::axiReq_t axiReq,
  output mem_power_pkg::axiRsp_t      axiRsp,
  output logic                        contactorCoil,
  output logic                        switchedOnLamp,
  output logic                        overtempLamp,
  output logic                        leftHalfFailClear,
  output logic                        rightHalfFailClear,
  output logic                        stackFailClear_n,
  output logic                        drivePowerGood,
  output logic                        driverLowVoltage_n,
  output logic                        inhibitPowerFail_n,
  output logic                        stackChargeWindow,
  output logic [1:0]                  memBusy,
  output logic [1:0]                  memDone,
  output logic [1:0]                  memAbort,
  output logic [1:0]                  halfReset
);

  mem_power_pkg::pins_t      pinSync;
  mem_power_pkg::powerState_t state_r;
  mem_power_pkg::powerState_t state_nxt;
  mem_power_pkg::status_t    status;

  logic [16:0] msCount_r;
  logic        msTick_r;
  logic [11:0] lampCnt_r;
  logic [11:0] holdCnt_r;
  logic [11:0] lockCnt_r;
  logic [11:0] flashCnt_r;
  logic        flash_r;
  logic        offLatch_r;
  logic        permit_r;
  logic        thermal_r;
  logic [1:0]  control_r;
  logic [3:0]  events_r;
  logic [1:0]  charge;

  // Pin inputs pass two flops before any logic looks at them.
  pin_sync #(
    .WIDTH ($bits(mem_power_pkg::pins_t))
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .pinIn   (pins),
    .pinSync (pinSync)
  );

  // Slow tick: one pulse per millisecond from the fast clock.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      msCount_r <= 17'h0_0000;
      msTick_r  <= 1'b0;
    end else if (ce) begin
      msTick_r  <= msCount_r == 17'(MS_CYCLES - 1);
      msCount_r <= (msCount_r == 17'(MS_CYCLES - 1)) ? 17'h0_0000
                                                     : msCount_r + 17'h0_0001;
    end
  end

  // Decoded pin levels, active high from here on.
  wire busPowerRequest = ~pinSync.busPowerOn_n;
  wire emergencyOff    = ~pinSync.busEmergencyOff_n;
  wire bypass          = pinSync.interlockBypass;
  wire airFault        = ~&pinSync.coolingOk;
  wire doorOpen        = ~&pinSync.doorClosed;
  wire lineOk          = pinSync.lineAcOk;

  wire powerRequest = busPowerRequest & pinSync.localSwitchOn;

  wire thermalTrip = thermal_r & ~bypass;
  wire doorTrip = doorOpen & ~bypass;

  wire permit = powerRequest & ~emergencyOff & ~thermalTrip & ~doorTrip &
                ~control_r[`CTL_SOFT_OFF];

  wire turnOn = offLatch_r & permit;

  wire lockDone   = lockCnt_r == 12'h000;
  wire permitFall = permit_r & ~permit;

  // Off-state latch and recycle lockout. The latch is held at zero
  // while permit is low so a permit glitch cannot skip the lockout.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      offLatch_r <= 1'b1;
      permit_r   <= 1'b0;
      lockCnt_r  <= 12'h000;
    end else if (ce) begin
      permit_r <= permit;
      offLatch_r <= permit & (offLatch_r | lockDone);
      if (permitFall) begin
        lockCnt_r <= `RECYCLE_MS;
      end else if (msTick_r && !lockDone) begin
        lockCnt_r <= lockCnt_r - 12'h001;
      end
    end
  end

  // Contactor state: off, driven, or holding after permit fell.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      mem_power_pkg::PWR_OFF: begin
        if (turnOn && lineOk) begin
          state_nxt = mem_power_pkg::PWR_ON;
        end
      end
      mem_power_pkg::PWR_ON: begin
        if (!turnOn) begin
          state_nxt = mem_power_pkg::PWR_HOLD;
        end
      end
      mem_power_pkg::PWR_HOLD: begin
        if (holdCnt_r == 12'h000) begin
          state_nxt = mem_power_pkg::PWR_OFF;
        end
      end
      default: state_nxt = mem_power_pkg::PWR_OFF;
    endcase
    if (!lineOk) begin
      state_nxt = mem_power_pkg::PWR_OFF;
    end
  end

  wire contactorDrive = state_r != mem_power_pkg::PWR_OFF;

  // The hold timer restarts on each entry, so a fresh permit fall
  // gets the full delay before the coil drops, unless lineOk falls first.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r       <= mem_power_pkg::PWR_OFF;
      holdCnt_r     <= 12'h000;
      contactorCoil <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      if (state_r != mem_power_pkg::PWR_HOLD) begin
        holdCnt_r <= `DRIVE_HOLD_MS;
      end else if (msTick_r && holdCnt_r != 12'h000) begin
        holdCnt_r <= holdCnt_r - 12'h001;
      end
      contactorCoil <= (state_nxt != mem_power_pkg::PWR_OFF) & lineOk;
    end
  end

  // Thermal latch: a brief air-flow dropout still trips the cabinet,
  // and it only clears once everything is off and the air is back.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      thermal_r    <= 1'b0;
      overtempLamp <= 1'b0;
    end else if (ce) begin
      if (airFault) begin
        thermal_r <= 1'b1;
      end else if (!contactorDrive && !contactorCoil) begin
        thermal_r <= 1'b0;
      end
      overtempLamp <= thermal_r | airFault;
    end
  end

  // Switched-on lamp delay and the maintenance flash.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lampCnt_r      <= `LAMP_DELAY_MS;
      flashCnt_r     <= `FLASH_HALF_MS;
      flash_r        <= 1'b0;
      switchedOnLamp <= 1'b0;
    end else if (ce) begin
      if (!pinSync.localSwitchOn) begin
        lampCnt_r <= `LAMP_DELAY_MS;
      end else if (msTick_r && lampCnt_r != 12'h000) begin
        lampCnt_r <= lampCnt_r - 12'h001;
      end
      if (msTick_r) begin
        flashCnt_r <= (flashCnt_r == 12'h000) ? `FLASH_HALF_MS
                                              : flashCnt_r - 12'h001;
        flash_r    <= flash_r ^ (flashCnt_r == 12'h000);
      end
      switchedOnLamp <= pinSync.localSwitchOn & (lampCnt_r == 12'h000) &
                        (~bypass | flash_r);
    end
  end

  // Supply and bias detection, active high.
  wire leftClear  = ~&pinSync.supplyLowTop_n;
  wire rightClear = ~pinSync.supplyLowBottom_n;
  wire biasFail   = ~pinSync.biasReturnSense;
  wire inhibitOk  = ~leftClear & ~rightClear & ~biasFail;

  // Protection outputs. These are registered once more than the
  // timers see the clears, trading one cycle for clean pins.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      leftHalfFailClear  <= 1'b1;
      rightHalfFailClear <= 1'b1;
      stackFailClear_n   <= 1'b0;
      drivePowerGood     <= 1'b0;
      driverLowVoltage_n <= 1'b1;
      inhibitPowerFail_n <= 1'b0;
      stackChargeWindow  <= 1'b0;
    end else if (ce) begin
      leftHalfFailClear  <= leftClear;
      rightHalfFailClear <= rightClear;
      stackFailClear_n   <= ~(leftClear | rightClear);
      drivePowerGood     <= inhibitOk;
      driverLowVoltage_n <= ~(inhibitOk & pinSync.driverPresent);
      inhibitPowerFail_n <= inhibitOk & pinSync.driverPresent;
      stackChargeWindow  <= |charge;
    end
  end

  half_cycle_timer u_left (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .ce         (ce),
    .failClear  (leftClear | biasFail),
    .enable     (control_r[`CTL_MEM_ENABLE]),
    .req        (memReq[0]),
    .write      (memWrite[0]),
    .busy       (memBusy[0]),
    .done       (memDone[0]),
    .abort      (memAbort[0]),
    .resetPulse (halfReset[0]),
    .charge     (charge[0])
  );

  half_cycle_timer u_right (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .ce         (ce),
    .failClear  (rightClear | biasFail),
    .enable     (control_r[`CTL_MEM_ENABLE]),
    .req        (memReq[1]),
    .write      (memWrite[1]),
    .busy       (memBusy[1]),
    .done       (memDone[1]),
    .abort      (memAbort[1]),
    .resetPulse (halfReset[1]),
    .charge     (charge[1])
  );

  // Status word, built from live state.
  assign status = '{
    zero:              16'h0000,
    powerState:        state_r,
    stackChargeWindow: stackChargeWindow,
    drivePowerGood:    drivePowerGood,
    biasFail:          biasFail,
    rightClear:        rightClear,
    leftClear:         leftClear,
    overtempLamp:      overtempLamp,
    switchedOnLamp:    switchedOnLamp,
    thermalFault:      thermal_r,
    contactorCoil:     contactorCoil,
    contactorDrive:    contactorDrive,
    lockoutActive:     ~lockDone,
    offLatch:          offLatch_r,
    permit:            permit_r,
    powerRequest:      powerRequest
  };

  // AXI4-Lite slave. Address and data are captured independently and
  // the write lands one cycle after both are held.
  logic        awHeld_r;
  logic        wHeld_r;
  logic [7:0]  awAddr_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        awReady_r;
  logic        wReady_r;
  logic        bValid_r;
  logic [1:0]  bResp_r;
  logic        arReady_r;
  logic        rValid_r;
  logic [31:0] rData_r;
  logic [1:0]  rResp_r;

  wire awTake  = axiReq.awvalid & awReady_r;
  wire wTake   = axiReq.wvalid & wReady_r;
  wire doWrite = awHeld_r & wHeld_r & ~bValid_r;
  wire arTake  = axiReq.arvalid & arReady_r;

  wire awHeldNxt = ~doWrite & (awHeld_r | awTake);
  wire wHeldNxt  = ~doWrite & (wHeld_r | wTake);
  wire bValidNxt = doWrite | (bValid_r & ~axiReq.bready);
  wire rValidNxt = arTake | (rValid_r & ~axiReq.rready);

  wire wrControl = doWrite & (awAddr_r == `REG_CONTROL);
  wire wrStatus  = doWrite & (awAddr_r == `REG_STATUS);
  wire wrEvents  = doWrite & (awAddr_r == `REG_EVENTS);
  wire wrMapped  = wrControl | wrStatus | wrEvents;

  wire [7:0] rdAddr = axiReq.araddr[7:0];
  wire rdMapped = (rdAddr == `REG_CONTROL) | (rdAddr == `REG_STATUS) |
                  (rdAddr == `REG_EVENTS);
  wire [31:0] rdMux =
      (rdAddr == `REG_CONTROL) ? {30'h0000_0000, control_r} :
      (rdAddr == `REG_STATUS)  ? status :
      (rdAddr == `REG_EVENTS)  ? {28'h000_0000, events_r} : 32'h0000_0000;

  // Hardware events; a set in the clearing cycle survives the clear.
  wire [3:0] eventSet = {biasFail, leftClear | rightClear,
                         doorOpen & contactorDrive, airFault};
  wire [3:0] eventClr = (wrEvents & wStrb_r[0]) ? wData_r[3:0] : 4'h0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awHeld_r  <= 1'b0;
      wHeld_r   <= 1'b0;
      awAddr_r  <= 8'h00;
      wData_r   <= 32'h0000_0000;
      wStrb_r   <= 4'h0;
      awReady_r <= 1'b1;
      wReady_r  <= 1'b1;
      bValid_r  <= 1'b0;
      bResp_r   <= `RESP_OKAY;
      arReady_r <= 1'b1;
      rValid_r  <= 1'b0;
      rData_r   <= 32'h0000_0000;
      rResp_r   <= `RESP_OKAY;
      control_r <= `CONTROL_RESET;
      events_r  <= 4'h0;
    end else if (ce) begin
      awHeld_r  <= awHeldNxt;
      wHeld_r   <= wHeldNxt;
      awReady_r <= ~awHeldNxt & ~bValidNxt;
      wReady_r  <= ~wHeldNxt & ~bValidNxt;
      bValid_r  <= bValidNxt;
      arReady_r <= ~rValidNxt;
      rValid_r  <= rValidNxt;
      if (awTake) begin
        awAddr_r <= axiReq.awaddr[7:0];
      end
      if (wTake) begin
        wData_r <= axiReq.wdata;
        wStrb_r <= axiReq.wstrb;
      end
      if (doWrite) begin
        bResp_r <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (wrControl && wStrb_r[0]) begin
        control_r <= wData_r[1:0];
      end
      events_r <= (events_r & ~eventClr) | eventSet;
      if (arTake) begin
        rData_r <= rdMux;
        rResp_r <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  assign axiRsp = '{
    awready: awReady_r,
    wready:  wReady_r,
    bvalid:  bValid_r,
    bresp:   bResp_r,
    arready: arReady_r,
    rvalid:  rValid_r,
    rdata:   rData_r,
    rresp:   rResp_r
  };

endmodule

// *** mem_power_map.svh ***
// Named constants for the memory cabinet power sequencer.
// Assumes a 100 MHz system clock and an AXI4-Lite register port.
`ifndef MEM_POWER_MAP_SVH
`define MEM_POWER_MAP_SVH

// Clock period and the length of one slow timing tick, in ns.
`define CLK_PERIOD_NS     10
`define MS_NS             1000000

// Sequencing times in milliseconds, counted on the slow tick.
`define LAMP_DELAY_MS     12'h0dc
`define DRIVE_HOLD_MS     12'h190
`define RECYCLE_MS        12'hfa0
`define FLASH_HALF_MS     12'h1f4

// Memory cycle length in ns and its count in clocks, and the restart pulse length in clocks.
`define MEM_CYCLE_NS      1200
`define MEM_CYCLE_CLKS    (`MEM_CYCLE_NS / `CLK_PERIOD_NS)
`define RESET_PULSE_CLKS  3'h4

// Register byte offsets on the low address byte.
`define REG_CONTROL       8'h00
`define REG_STATUS        8'h04
`define REG_EVENTS        8'h08

// Control fields and reset value.
`define CTL_MEM_ENABLE    0
`define CTL_SOFT_OFF      1
`define CONTROL_RESET     2'h1

// Sticky event fields.
`define EVT_THERMAL       0
`define EVT_DOOR          1
`define EVT_SUPPLY        2
`define EVT_BIAS          3

// Bus responses.
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// *** mem_power_pkg.sv ***
// Types shared by the power sequencer files.
// Assumes mem_power_map.svh supplies every timing and register constant; the state encodings are set here.
package mem_power_pkg;

  typedef enum logic [1:0] {
    PWR_OFF  = 2'b00,
    PWR_ON   = 2'b01,
    PWR_HOLD = 2'b10
  } powerState_t;

  typedef enum logic [1:0] {
    HALF_IDLE    = 2'b00,
    HALF_RUN     = 2'b01,
    HALF_RECOVER = 2'b10
  } halfState_t;

  // Asynchronous pin inputs, all synchronised together.
  typedef struct packed {
    logic       busPowerOn_n;
    logic       busEmergencyOff_n;
    logic       localSwitchOn;
    logic [1:0] supplyLowTop_n;
    logic       supplyLowBottom_n;
    logic       lineAcOk;
    logic [3:0] coolingOk;
    logic [1:0] doorClosed;
    logic       interlockBypass;
    logic       biasReturnSense;
    logic       driverPresent;
  } pins_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axiReq_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axiRsp_t;

  // Live state shown in the status register, low half of the word.
  typedef struct packed {
    logic [15:0] zero;
    powerState_t powerState;
    logic        stackChargeWindow;
    logic        drivePowerGood;
    logic        biasFail;
    logic        rightClear;
    logic        leftClear;
    logic        overtempLamp;
    logic        switchedOnLamp;
    logic        thermalFault;
    logic        contactorCoil;
    logic        contactorDrive;
    logic        lockoutActive;
    logic        offLatch;
    logic        permit;
    logic        powerRequest;
  } status_t;

endpackage

// *** pin_sync.sv ***
// Two-flop synchroniser for a group of pin inputs.
// Assumes the pins change slowly relative to the clock.
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] stage1_r;

  // Only the second stage is read outside this module.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1_r <= '0;
      pinSync  <= '0;
    end else if (ce) begin
      stage1_r <= pinIn;
      pinSync  <= stage1_r;
    end
  end

endmodule

// *** half_cycle_timer.sv ***
// Cycle timing for one stack half, with fail clear and restart pulse.
// Assumes req and write come from logic on the same clock.
`include "mem_power_map.svh"
`timescale 1ns/10ps
module half_cycle_timer (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic failClear,
  input  wire logic enable,
  input  wire logic req,
  input  wire logic write,
  output logic      busy,
  output logic      done,
  output logic      abort,
  output logic      resetPulse,
  output logic      charge
);

  mem_power_pkg::halfState_t state_r;
  mem_power_pkg::halfState_t state_nxt;
  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic       start;
  logic       finish;

  // A start needs no clear, no restart pulse and an idle timer.
  assign start  = req & enable & ~failClear &
                  (state_r == mem_power_pkg::HALF_IDLE);
  assign finish = (state_r != mem_power_pkg::HALF_IDLE) & (cnt_r == 7'h00);

  // Next state; a clear overrides everything and parks the timer.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      mem_power_pkg::HALF_IDLE: begin
        if (start) begin
          state_nxt = mem_power_pkg::HALF_RUN;
          cnt_nxt   = 7'(`MEM_CYCLE_CLKS - 1);
        end
      end
      mem_power_pkg::HALF_RUN, mem_power_pkg::HALF_RECOVER: begin
        cnt_nxt = cnt_r - 7'h01;
        if (finish) begin
          state_nxt = mem_power_pkg::HALF_IDLE;
          cnt_nxt   = 7'h00;
        end
      end
      default: state_nxt = mem_power_pkg::HALF_IDLE;
    endcase
    if (failClear) begin
      state_nxt = mem_power_pkg::HALF_RECOVER;
      cnt_nxt   = 7'({4'h0, `RESET_PULSE_CLKS} - 7'h01);
    end
  end

  // Outputs are flops so the top can drive its pins from them directly.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r    <= mem_power_pkg::HALF_IDLE;
      cnt_r      <= 7'h00;
      busy       <= 1'b0;
      done       <= 1'b0;
      abort      <= 1'b0;
      resetPulse <= 1'b0;
      charge     <= 1'b0;
    end else if (ce) begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      busy       <= state_nxt == mem_power_pkg::HALF_RUN;
      done       <= (state_r == mem_power_pkg::HALF_RUN) & finish & ~failClear;
      abort      <= (state_r == mem_power_pkg::HALF_RUN) & failClear;
      resetPulse <= state_nxt == mem_power_pkg::HALF_RECOVER;
      charge     <= (state_nxt == mem_power_pkg::HALF_RUN) &
                    (start ? write : charge);
    end
  end

endmodule

// *** power_bus_model.sv ***
// Power control bus lines shared with the other cabinets.
// Both lines are pulled up; any cabinet may ground either one.
`timescale 1ns/10ps
module power_bus_model (
  input  wire logic groundOn,
  input  wire logic groundOff,
  output logic      busPowerOn_n,
  output logic      busEmergencyOff_n
);
  assign busPowerOn_n = !groundOn;
  assign busEmergencyOff_n = !groundOff;
endmodule

// *** mem_power_sequencer_monitor.sv ***
// Port checker for the power sequencer.
// Assumes it is bound into every sequencer instance.
`timescale 1ns/10ps
module mem_power_sequencer_monitor #(
  parameter int MS_CYCLES = 10
) (
  input wire logic sys_clk, rst, ce,
  input wire mem_power_pkg::pins_t pins,
  input wire logic [1:0] memReq, memWrite, memBusy, memDone,
  input wire logic [1:0] memAbort, halfReset,
  input wire mem_power_pkg::axiReq_t axiReq,
  input wire mem_power_pkg::axiRsp_t axiRsp,
  input wire logic contactorCoil, switchedOnLamp, overtempLamp,
  input wire logic leftHalfFailClear, rightHalfFailClear,
  input wire logic stackFailClear_n, drivePowerGood,
  input wire logic driverLowVoltage_n, inhibitPowerFail_n,
  input wire logic stackChargeWindow
);
  // Two-cycle antecedents leave room for the output registers.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  clear_gens_a: assert property ((leftHalfFailClear || rightHalfFailClear)
    [*2] |-> !drivePowerGood) else $error("drive good in clear");
  clear_join_a: assert property ((leftHalfFailClear || rightHalfFailClear)
    [*2] |-> !stackFailClear_n) else $error("no joint clear");
  clear_idle_a: assert property (leftHalfFailClear[*2] |-> !memBusy[0])
    else $error("cycle runs in clear");
  abort_run_a: assert property (memAbort[0] |-> $past(memBusy[0]))
    else $error("abort while idle");
  inhibit_off_a: assert property (driverLowVoltage_n[*2] |->
    !inhibitPowerFail_n) else $error("inhibit enabled");
  charge_busy_a: assert property (stackChargeWindow |->
    $past(memBusy) != 2'h0) else $error("charge while idle");
  line_loss_a: assert property (!pins.lineAcOk[*4] |-> !contactorCoil)
    else $error("coil without line");
  restart_pulse_a: assert property ($fell(leftHalfFailClear) |->
    halfReset[0]) else $error("no restart pulse");
  lamp_cause_a: assert property ($rose(switchedOnLamp) |->
    pins.localSwitchOn) else $error("lamp without switch");
  bresp_hold_a: assert property (axiRsp.bvalid && !axiReq.bready |=>
    axiRsp.bvalid && $stable(axiRsp.bresp)) else $error("bresp dropped");
  cover property ($rose(contactorCoil));
  cover property (memAbort[0]);
  cover property (memDone[0]);
endmodule

bind mem_power_sequencer mem_power_sequencer_monitor #(
  .MS_CYCLES(MS_CYCLES)) u_mon (.*);

// *** test_mem_power_sequencer.sv ***
// Self-checking bench for the power sequencer.
// Assumes MS_CYCLES of 10, so one ms is ten clocks.
`timescale 1ns/10ps
module test_mem_power_sequencer;
  logic                   sys_clk = 0, rst = 1, ce = 1;
  logic                   gOn = 0, gOff = 0, w;
  logic [13:0]            rest = 14'h3ffb;
  logic [1:0]             req = 0, wr = 0, busy, done, abt, hr;
  logic                   coil, lamp, ot, lc, rc, sfc, dpg, dlv, ipf, scw;
  wire                    onN, offN;
  mem_power_pkg::pins_t   pins;
  mem_power_pkg::axiReq_t rq = '0;
  mem_power_pkg::axiRsp_t rs, rsN;
  logic [33:0]            expQ[$];
  int                     errors = 0, total_checks = 0, cyc = 0, i;
  int                     lowCnt = 0;
  integer                 seed = 32'hc9df_5ae0;

  assign pins = {onN, offN, rest};
  power_bus_model u_bus (.groundOn(gOn), .groundOff(gOff),
    .busPowerOn_n(onN), .busEmergencyOff_n(offN));
  mem_power_sequencer #(.MS_CYCLES(10)) u_dut (.sys_clk(sys_clk),
    .rst(rst), .ce(ce), .pins(pins), .memReq(req), .memWrite(wr),
    .axiReq(rq), .axiRsp(rs), .contactorCoil(coil),
    .switchedOnLamp(lamp), .overtempLamp(ot), .leftHalfFailClear(lc),
    .rightHalfFailClear(rc), .stackFailClear_n(sfc),
    .drivePowerGood(dpg), .driverLowVoltage_n(dlv),
    .inhibitPowerFail_n(ipf), .stackChargeWindow(scw), .memBusy(busy),
    .memDone(done), .memAbort(abt), .halfReset(hr));

  initial forever #5 sys_clk = ~sys_clk;
  // Snapshot at the falling edge avoids racing the registered answers.
  always @(negedge sys_clk) rsN = rs;

  task automatic check(string nm, logic [33:0] seen, logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic axw(logic [31:0] a, logic [31:0] d, logic [1:0] r);
    expQ.push_back({r, 32'h0000_0000});
    @(posedge sys_clk);
    rq.awaddr <= a; rq.wdata <= d; rq.wstrb <= 4'hf;
    rq.awvalid <= 1; rq.wvalid <= 1; rq.bready <= 1;
    do begin
      @(posedge sys_clk);
      if (rsN.awready) rq.awvalid <= 0;
      if (rsN.wready) rq.wvalid <= 0;
    end while (!rsN.bvalid);
    rq.bready <= 0;
  endtask

  task automatic axr(logic [31:0] a, logic [33:0] e);
    expQ.push_back(e);
    @(posedge sys_clk);
    rq.araddr <= a; rq.arvalid <= 1; rq.rready <= 1;
    do begin
      @(posedge sys_clk);
      if (rsN.arready) rq.arvalid <= 0;
    end while (!rsN.rvalid);
    rq.rready <= 0;
  endtask

  task automatic ticks(int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Responses are matched against the oldest expectation.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rsN.bvalid && rq.bready)
      check("bresp", {rsN.bresp, 32'h0000_0000}, expQ.pop_front());
    if (rsN.rvalid && rq.rready)
      check("rdata", {rsN.rresp, rsN.rdata}, expQ.pop_front());
    if (cyc == 95000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 0;
    gOn <= 1;
    axw(32'h0000_0000, ($random(seed) & 32'hffff_fffc) | 1, 2'h0);
    axr(32'h0000_0000, {2'h0, 32'h0000_0001});
    axw(32'h0000_001c, 32'h0000_0000, 2'h2);
    axr(32'h0000_0010, {2'h2, 32'h0000_0000});
    ticks(2080);
    check("lamp", lamp, 1'b0);
    ticks(200);
    check("lamp", lamp, 1'b1);
    for (i = 0; i < 45000 && coil !== 1'b1; i++) ticks(1);
    check("coil", coil, 1'b1);
    @(posedge sys_clk) gOff <= 1;
    ticks(3900);
    check("coil", coil, 1'b1);
    ticks(200);
    check("coil", coil, 1'b0);
    @(posedge sys_clk) gOff <= 0;
    ticks(20000);
    check("coil", coil, 1'b0);
    // One full cycle, then one cut short by a supply low.
    for (int n = 0; n < 2; n++) begin
      w = $random(seed);
      @(posedge sys_clk) begin req[0] <= 1; wr[0] <= w; end
      do ticks(1); while (busy[0] !== 1'b1);
      @(posedge sys_clk) req[0] <= 0;
      ticks(3);
      check("charge", scw, w);
      if (n == 1) begin
        @(posedge sys_clk) rest[12] <= 0;
        ticks(6);
        check("left", {lc, rc, dpg, busy[0]}, 4'h8);
        @(posedge sys_clk) rest[12] <= 1;
      end
      ticks(130);
    end
    // Supply, bias and module loss all inhibit the drivers.
    foreach (rest[k]) if (k == 10 || k < 2) begin
      @(posedge sys_clk) rest[k] <= 0;
      ticks(6);
      check("inhibit", {dlv, ipf}, 2'h2);
      @(posedge sys_clk) rest[k] <= 1;
      ticks(10);
    end
    // Lockout has run out by now, so the cabinet powers up again.
    ticks(16000);
    check("coil", coil, 1'b1);
    // Bypass on, then an air-flow fault: lamp lights, power stays.
    @(posedge sys_clk) rest[2] <= 1;
    @(posedge sys_clk) rest[5] <= 0;
    ticks(10);
    check("bypass", {ot, coil}, 2'h3);
    // A flashing lamp is dark for roughly half of two half periods.
    for (i = 0; i < 10100; i++) begin
      ticks(1);
      lowCnt += (lamp === 1'b0);
    end
    check("flash", (lowCnt > 4000) && (lowCnt < 6100), 1'b1);
    final_report();
  end
endmodule
